// ### rtl/flow_pkg.sv
package flow_pkg;
  localparam int          PC_W          = 21;
  localparam int          SP_W          = 5;
  localparam int          DEPTH         = 31;
  localparam logic [11:0] PTR_STAT_ADDR = 12'hffc;
  localparam logic [11:0] TOP_LOW_ADDR  = 12'hffd;
  localparam logic [11:0] TOP_HIGH_ADDR = 12'hffe;
  localparam logic [11:0] TOP_UPPER_ADDR = 12'hfff;
  localparam int          FULL_BIT      = 7;
  localparam int          UNF_BIT       = 6;
  localparam logic [4:0]  SP_RESET      = 5'h00;
  localparam logic [4:0]  SP_MAX        = 5'h1f;
  localparam logic [20:0] PC_STEP       = 21'h000002;
  localparam logic [20:0] PC_RESET      = 21'h000000;
  localparam logic [1:0]  PHASE_COUNT_MAX = 2'h3;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } phase_e;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working;
    logic [7:0] bank;
  } ctx_s;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic        call;
    logic        ret;
    logic        fast;
    logic        irq_vector;
    logic        branch;
    logic        table_read;
    logic [20:0] target;
  } ctrl_s;
endpackage : flow_pkg

// ### rtl/phase_gen.sv
`timescale 1ns/100ps
module phase_gen (
  input  wire logic            mclk_in,    // Core clock
  input  wire logic            rst_n_in,   // Sync reset
  output flow_pkg::phase_e     phase_out,  // Current phase
  output logic                 cycle_end_out // High in last phase
);
  flow_pkg::phase_e phase_reg;
  flow_pkg::phase_e phase_next;

  always_comb begin
    unique case (phase_reg)
      flow_pkg::PH_Q1: phase_next = flow_pkg::PH_Q2;
      flow_pkg::PH_Q2: phase_next = flow_pkg::PH_Q3;
      flow_pkg::PH_Q3: phase_next = flow_pkg::PH_Q4;
      flow_pkg::PH_Q4: phase_next = flow_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      phase_reg <= flow_pkg::PH_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase_out     = phase_reg;
  assign cycle_end_out = (phase_reg == flow_pkg::PH_Q4);

  sequence q2_to_next_q1;
    phase_reg == flow_pkg::PH_Q2 ##1 phase_reg == flow_pkg::PH_Q3 ##1
    phase_reg == flow_pkg::PH_Q4 ##1 phase_reg == flow_pkg::PH_Q1;
  endsequence

  // Sampled reset in the antecedent: the release edge still holds Q1
  chk_phase_order: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    rst_n_in && phase_reg == flow_pkg::PH_Q1 |=> q2_to_next_q1)
    else $error("phase order broken");
endmodule : phase_gen

// ### rtl/return_stack_and_fetch_pipeline.sv
`timescale 1ns/100ps
module return_stack_and_fetch_pipeline #(
  parameter int DEPTH = flow_pkg::DEPTH
) (
  input  wire logic           mclk_in,         // Core clock
  input  wire logic           rst_n_in,        // Sync reset, any cause
  input  wire logic           por_n_in,        // Power-on reset, active low
  input  wire logic           err_reset_en_in, // Stack error reset enable
  input  wire flow_pkg::ctrl_s ctrl_in,        // Execute-stage controls
  input  wire logic [11:0]    sfr_addr_in,     // Register address
  input  wire logic           sfr_wr_in,       // Register write strobe
  input  wire logic [7:0]     sfr_wdata_in,    // Register write data
  output logic [7:0]          sfr_rdata_out,   // Register read data
  input  wire flow_pkg::ctx_s ctx_in,          // Live status/working/bank
  output flow_pkg::ctx_s      ctx_restore_out, // Shadow context
  output logic                ctx_restore_en_out, // Restore strobe
  input  wire logic [15:0]    prog_word_in,    // Program memory word
  input  wire logic [7:0]     prog_byte_in,    // Program memory byte
  output logic [20:0]         pc_out,          // Fetch address
  output logic [20:0]         table_ptr_out,   // Table byte address
  input  wire logic [20:0]    table_ptr_in,    // Table pointer load value
  input  wire logic           table_ptr_wr_in, // Table pointer load
  output logic [7:0]          table_latch_out, // Table latch
  output logic [15:0]         instr_out,       // Instruction register
  output logic                instr_valid_out, // Instruction not flushed
  output logic                data_read_out,   // Operand read phase
  output logic                data_write_out,  // Destination write phase
  output logic                device_reset_out // Stack error reset pulse
);
  flow_pkg::phase_e phase;
  logic             cycle_end;

  phase_gen u_phase (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n_in),
    .phase_out     (phase),
    .cycle_end_out (cycle_end)
  );

  logic [20:0] stack_mem [1:DEPTH];
  logic [4:0]  sp_reg, sp_next;
  logic        full_reg, full_next, unf_reg, unf_next;
  logic [20:0] pc_reg, pc_next;
  logic [15:0] ir_reg, ir_next;
  logic        valid_reg, valid_next, flush_reg, flush_next;
  logic        dres_reg, dres_next;
  logic        wr_en;
  logic [4:0]  wr_idx;
  logic [20:0] wr_val;
  logic [20:0] top_val;
  flow_pkg::ctx_s shadow_reg, shadow_next;
  logic        rest_reg, rest_next;
  logic [20:0] tptr_reg, tptr_next;
  logic [7:0]  tlat_reg, tlat_next;
  logic        exec, do_push, do_pop, ret_fast;

  function automatic logic [20:0] set_byte(input logic [20:0] v,
                                           input logic [1:0] sel,
                                           input logic [7:0] b);
    logic [20:0] r;
    r = v;
    unique case (sel)
      2'h0: r[7:0] = b;
      2'h1: r[15:8] = b;
      default: r[20:16] = b[4:0];
    endcase
    return r;
  endfunction : set_byte

  assign top_val  = (sp_reg == flow_pkg::SP_RESET) ? flow_pkg::PC_RESET
                    : stack_mem[sp_reg];
  assign exec     = cycle_end && valid_reg;
  assign do_push  = exec && (ctrl_in.push || ctrl_in.call
                    || ctrl_in.irq_vector);
  assign do_pop   = exec && (ctrl_in.pop || ctrl_in.ret) && !do_push;
  assign ret_fast = exec && ctrl_in.ret && ctrl_in.fast;

  always_comb begin
    sp_next   = sp_reg;
    full_next = full_reg;
    unf_next  = unf_reg;
    pc_next   = pc_reg;
    dres_next = 1'b0;
    wr_en     = 1'b0;
    wr_idx    = sp_reg;
    wr_val    = pc_reg;
    if (sfr_wr_in && sfr_addr_in == flow_pkg::PTR_STAT_ADDR) begin
      sp_next = sfr_wdata_in[4:0];
      if (!sfr_wdata_in[flow_pkg::FULL_BIT]) full_next = 1'b0;
      if (!sfr_wdata_in[flow_pkg::UNF_BIT])  unf_next  = 1'b0;
    end else if (sfr_wr_in && sp_reg != flow_pkg::SP_RESET
                 && sfr_addr_in >= flow_pkg::TOP_LOW_ADDR) begin
      wr_en  = 1'b1;
      wr_val = set_byte(top_val, 2'(sfr_addr_in - flow_pkg::TOP_LOW_ADDR),
                        sfr_wdata_in);
    end
    if (phase == flow_pkg::PH_Q1) begin
      pc_next = pc_reg + flow_pkg::PC_STEP;
    end
    if (do_push) begin
      if (sp_reg != flow_pkg::SP_MAX) begin
        sp_next = sp_reg + 5'h01;
        wr_en   = 1'b1;
        wr_idx  = sp_reg + 5'h01;
        wr_val  = pc_reg;
      end
      if (sp_reg >= flow_pkg::SP_MAX - 5'h01) begin
        full_next = 1'b1;
        if (err_reset_en_in) begin
          dres_next = 1'b1;
        end
      end
    end else if (do_pop) begin
      if (sp_reg == flow_pkg::SP_RESET) begin
        unf_next = 1'b1;
        if (ctrl_in.ret) pc_next = flow_pkg::PC_RESET;
        dres_next = err_reset_en_in;
      end else begin
        sp_next = sp_reg - 5'h01;
        if (ctrl_in.ret) pc_next = top_val;
      end
    end
    if (exec && ctrl_in.branch && !do_pop) begin
      pc_next = ctrl_in.target;
    end
    if (dres_reg) begin
      sp_next = flow_pkg::SP_RESET;
      pc_next = flow_pkg::PC_RESET;
    end
  end

  always_comb begin
    ir_next    = ir_reg;
    valid_next = valid_reg;
    flush_next = flush_reg;
    if (exec && (ctrl_in.branch || ctrl_in.call || ctrl_in.ret
                 || ctrl_in.irq_vector)) begin
      flush_next = 1'b1;
    end
    if (phase == flow_pkg::PH_Q4) begin
      ir_next    = prog_word_in;
      valid_next = !flush_next;
      flush_next = 1'b0;
    end
  end

  always_comb begin
    shadow_next = shadow_reg;
    rest_next   = 1'b0;
    if (exec && (ctrl_in.irq_vector || (ctrl_in.call && ctrl_in.fast))) begin
      shadow_next = ctx_in;
    end
    if (ret_fast) begin
      rest_next = 1'b1;
    end
  end

  always_comb begin
    tptr_next = table_ptr_wr_in ? table_ptr_in : tptr_reg;
    tlat_next = tlat_reg;
    if (exec && ctrl_in.table_read) begin
      tlat_next = prog_byte_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (wr_en) begin
      stack_mem[wr_idx] <= wr_val;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!por_n_in) begin
      full_reg <= 1'b0;
      unf_reg  <= 1'b0;
    end else begin
      full_reg <= full_next;
      unf_reg  <= unf_next;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !por_n_in) begin
      sp_reg     <= flow_pkg::SP_RESET;
      pc_reg     <= flow_pkg::PC_RESET;
      dres_reg   <= 1'b0;
      ir_reg     <= 16'h0000;
      valid_reg  <= 1'b0;
      flush_reg  <= 1'b0;
      shadow_reg <= '0;
      rest_reg   <= 1'b0;
      tptr_reg   <= flow_pkg::PC_RESET;
      tlat_reg   <= 8'h00;
    end else begin
      sp_reg     <= sp_next;
      pc_reg     <= pc_next;
      dres_reg   <= dres_next;
      ir_reg     <= ir_next;
      valid_reg  <= valid_next;
      flush_reg  <= flush_next;
      shadow_reg <= shadow_next;
      rest_reg   <= rest_next;
      tptr_reg   <= tptr_next;
      tlat_reg   <= tlat_next;
    end
  end

  always_comb begin
    unique case (sfr_addr_in)
      flow_pkg::PTR_STAT_ADDR:
        sfr_rdata_out = {full_reg, unf_reg, 1'b0, sp_reg};
      flow_pkg::TOP_LOW_ADDR:   sfr_rdata_out = top_val[7:0];
      flow_pkg::TOP_HIGH_ADDR:  sfr_rdata_out = top_val[15:8];
      flow_pkg::TOP_UPPER_ADDR: sfr_rdata_out = {3'h0, top_val[20:16]};
      default:                  sfr_rdata_out = 8'h00;
    endcase
  end

  assign ctx_restore_out    = shadow_reg;
  assign ctx_restore_en_out = rest_reg;
  assign pc_out             = pc_reg;
  assign table_ptr_out      = tptr_reg;
  assign table_latch_out    = tlat_reg;
  assign instr_out          = ir_reg;
  assign instr_valid_out    = valid_reg;
  assign data_read_out      = (phase == flow_pkg::PH_Q2) && valid_reg;
  assign data_write_out     = exec;
  assign device_reset_out   = dres_reg;

  chk_push_inc: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in || !por_n_in)
    do_push && sp_reg < 5'h1e && !sfr_wr_in && !dres_reg
    |=> sp_reg == $past(sp_reg) + 5'h01)
    else $error("push did not advance pointer");
  chk_push_store: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in || !por_n_in)
    do_push && sp_reg != flow_pkg::SP_MAX && !sfr_wr_in && !dres_reg
    |=> top_val == $past(pc_reg))
    else $error("push did not store counter");
  chk_pop_dec: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in || !por_n_in)
    do_pop && sp_reg != 5'h00 && !sfr_wr_in && !dres_reg
    |=> sp_reg == $past(sp_reg) - 5'h01)
    else $error("pop did not drop pointer");
  chk_full_sticky: assert property (@(posedge mclk_in) disable iff (!por_n_in)
    full_reg && !(sfr_wr_in && sfr_addr_in == flow_pkg::PTR_STAT_ADDR)
    |=> full_reg)
    else $error("full flag lost");
  chk_unf_empty: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in || !por_n_in)
    do_pop && sp_reg == 5'h00 |=> unf_reg && sp_reg == 5'h00)
    else $error("underflow not flagged");
  sequence pulse_then_cleared;
    device_reset_out ##1 sp_reg == flow_pkg::SP_RESET;
  endsequence
  chk_err_reset: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in || !por_n_in)
    do_push && sp_reg == 5'h1e && err_reset_en_in
    |=> pulse_then_cleared)
    else $error("stack error reset missing");
  chk_no_reset: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in || !por_n_in)
    !err_reset_en_in |=> !device_reset_out)
    else $error("reset while disabled");
  chk_sp_cap: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in || !por_n_in)
    do_push && sp_reg == 5'h1f && !err_reset_en_in && !sfr_wr_in
    |=> sp_reg == 5'h1f)
    else $error("pointer moved past top");
  chk_shadow_cap: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in || !por_n_in)
    exec && ctrl_in.irq_vector |=> shadow_reg == $past(ctx_in))
    else $error("shadow not captured");
  chk_fast_ret: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in || !por_n_in)
    ret_fast |=> ctx_restore_en_out)
    else $error("fast return no restore");
  chk_top_zero: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in || !por_n_in)
    sp_reg == 5'h00 && sfr_addr_in == flow_pkg::TOP_LOW_ADDR
    |-> sfr_rdata_out == 8'h00)
    else $error("empty top not zero");
endmodule : return_stack_and_fetch_pipeline

// ### dv/core_model.sv
`timescale 1ns/100ps
module core_model (
  input  wire logic           mclk_in,     // Core clock
  input  wire logic [20:0]    pc_in,       // Fetch address
  input  wire logic [20:0]    tp_in,       // Table byte address
  input  wire flow_pkg::ctx_s shadow_in,   // Shadow context
  input  wire logic           restore_in,  // Restore strobe
  input  wire logic           load_in,     // Bench context load
  input  wire flow_pkg::ctx_s load_ctx_in, // Bench context value
  output flow_pkg::ctx_s      ctx_out,     // Live context
  output logic [15:0]         word_out,    // Program word
  output logic [7:0]          byte_out     // Table byte
);
  // Contents follow the address, so a stale fetch shows up
  assign word_out = pc_in[16:1] ^ 16'h5a5a;
  assign byte_out = tp_in[7:0] ^ tp_in[15:8] ^ 8'h3c;
  // A restore wins over a bench load, as in the real core
  always @(posedge mclk_in) begin
    if (restore_in) begin
      ctx_out <= shadow_in;
    end else if (load_in) begin
      ctx_out <= load_ctx_in;
    end
  end
endmodule : core_model

// ### dv/return_stack_and_fetch_pipeline_test.sv
`timescale 1ns/100ps
module return_stack_and_fetch_pipeline_test;
  logic            mclk_in;
  logic            rst_n_in;
  logic            por_n_in;
  logic            err_en;
  flow_pkg::ctrl_s ctrl;
  logic [11:0]     addr;
  logic            wr_en;
  logic [7:0]      wdata;
  logic [7:0]      rdata;
  flow_pkg::ctx_s  ctx;
  flow_pkg::ctx_s  shadow;
  logic            restore;
  logic [15:0]     word;
  logic [7:0]      pbyte;
  logic [20:0]     pc;
  logic [20:0]     tp;
  logic [20:0]     tp_ld;
  logic            tp_wr;
  logic [7:0]      latch;
  logic            valid;
  logic [15:0]     instr;
  logic            drd;
  logic            dwr;
  logic            dres;
  logic            ld;
  flow_pkg::ctx_s  ld_ctx;
  logic [20:0]     p0;
  logic            seen;
  int              error_cnt;
  int              cmp_count;
  int              resets;
  int              cyc;
  // Opcode bits push pop call ret fast irq, then expected status
  localparam logic [13:0] ROWS [6] = '{
    {6'h20, 8'h01}, {6'h20, 8'h02}, {6'h10, 8'h01},
    {6'h10, 8'h00}, {6'h10, 8'h40}, {6'h20, 8'h41}};

  return_stack_and_fetch_pipeline u_return_stack_and_fetch_pipeline (
    .mclk_in            (mclk_in),
    .rst_n_in           (rst_n_in),
    .por_n_in           (por_n_in),
    .err_reset_en_in    (err_en),
    .ctrl_in            (ctrl),
    .sfr_addr_in        (addr),
    .sfr_wr_in          (wr_en),
    .sfr_wdata_in       (wdata),
    .sfr_rdata_out      (rdata),
    .ctx_in             (ctx),
    .ctx_restore_out    (shadow),
    .ctx_restore_en_out (restore),
    .prog_word_in       (word),
    .prog_byte_in       (pbyte),
    .pc_out             (pc),
    .table_ptr_out      (tp),
    .table_ptr_in       (tp_ld),
    .table_ptr_wr_in    (tp_wr),
    .table_latch_out    (latch),
    .instr_out          (instr),
    .instr_valid_out    (valid),
    .data_read_out      (drd),
    .data_write_out     (dwr),
    .device_reset_out   (dres)
  );

  core_model u_core_model (
    .mclk_in     (mclk_in),
    .pc_in       (pc),
    .tp_in       (tp),
    .shadow_in   (shadow),
    .restore_in  (restore),
    .load_in     (ld),
    .load_ctx_in (ld_ctx),
    .ctx_out     (ctx),
    .word_out    (word),
    .byte_out    (pbyte)
  );

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic close_out;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk_in) begin
    cyc++;
    if (dres === 1'b1) begin
      resets++;
    end
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick

  task automatic settle;
    @(posedge mclk_in);
    #1;
  endtask : settle

  // Returns on the edge that closes a valid last phase
  task automatic take;
    int k;
    k = 0;
    @(posedge mclk_in);
    while (dwr !== 1'b1 && k < 40) begin
      @(posedge mclk_in);
      k++;
    end
  endtask : take

  task automatic op(input flow_pkg::ctrl_s c);
    take();
    ctrl <= c;
    take();
    ctrl <= '0;
    tick(2);
  endtask : op

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk_in);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge mclk_in);
    addr <= a;
    settle();
    chk({16'h0, rdata}, {16'h0, exp});
  endtask : rchk

  task automatic load(input logic [23:0] v);
    @(posedge mclk_in);
    ld <= 1'b1;
    ld_ctx <= v;
    @(posedge mclk_in);
    ld <= 1'b0;
  endtask : load

  initial begin
    {rst_n_in, por_n_in, err_en, wr_en, tp_wr, seen} = '0;
    {ctrl, addr, wdata, tp_ld, p0, ld_ctx} = '0;
    {error_cnt, cmp_count, resets, cyc} = '0;
    ld = 1'b1;
    tick(8);
    rst_n_in <= 1'b1;
    por_n_in <= 1'b1;
    ld <= 1'b0;
    rchk(12'hffc, 8'h00);
    for (int i = 0; i < 6; i++) begin
      op({ROWS[i][13:8], 23'h0});
      rchk(12'hffc, ROWS[i][7:0]);
    end
    load(24'h112233);
    op({6'h0a, 23'h0});
    load(24'h445566);
    op({6'h06, 23'h0});
    chk(ctx, 24'h112233);
    load(24'h778899);
    op({6'h01, 23'h0});
    load(24'haabbcc);
    op({6'h01, 23'h0});
    load(24'hddeeff);
    op({6'h04, 23'h0});
    chk(ctx, 24'hddeeff);
    op({6'h06, 23'h0});
    chk(ctx, 24'haabbcc);
    wr(12'hffc, 8'h3f);
    rchk(12'hffc, 8'h1f);
    wr(12'hfff, 8'hff);
    rchk(12'hfff, 8'h1f);
    wr(12'hffc, 8'h1e);
    op({6'h20, 23'h0});
    rchk(12'hffc, 8'h9f);
    wr(12'hffd, 8'h5a);
    op({6'h20, 23'h0});
    rchk(12'hffc, 8'h9f);
    rchk(12'hffd, 8'h5a);
    chk(24'(resets), 24'h0);
    wr(12'hffc, 8'h00);
    wr(12'hffd, 8'ha5);
    rchk(12'hffd, 8'h00);
    err_en <= 1'b1;
    wr(12'hffc, 8'h1e);
    op({6'h20, 23'h0});
    tick(4);
    rchk(12'hffc, 8'h80);
    op({6'h10, 23'h0});
    tick(4);
    rchk(12'hffc, 8'hc0);
    chk(24'(resets), 24'h2);
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    err_en <= 1'b0;
    tick(2);
    rst_n_in <= 1'b1;
    rchk(12'hffc, 8'hc0);
    @(posedge mclk_in);
    por_n_in <= 1'b0;
    tick(2);
    por_n_in <= 1'b1;
    rchk(12'hffc, 8'h00);
    @(posedge mclk_in);
    tp_ld <= 21'h000123;
    tp_wr <= 1'b1;
    @(posedge mclk_in);
    tp_wr <= 1'b0;
    op({8'h01, 21'h0});
    chk({16'h0, latch}, 24'h00001e);
    // Look only at settled values, except take(), which polls dwr in the edge's own time step
    settle();
    repeat (8) begin
      if (drd !== 1'b1) begin
        settle();
      end
    end
    p0 = pc;
    tick(1);
    settle();
    chk({23'h0, dwr}, 24'h1);
    tick(1);
    settle();
    chk({23'h0, drd}, 24'h1);
    chk({3'h0, pc}, {3'h0, p0 + flow_pkg::PC_STEP});
    chk({8'h0, instr}, {8'h0, p0[16:1] ^ 16'h5a5a});
    take();
    ctrl <= {8'h02, 21'h000400};
    take();
    ctrl <= '0;
    repeat (6) begin
      settle();
      if (valid === 1'b0) begin
        seen = 1'b1;
      end
    end
    chk({23'h0, seen}, 24'h1);
    chk({3'h0, pc & 21'h1ffff8}, 24'h000400);
    close_out();
  end
endmodule : return_stack_and_fetch_pipeline_test
